// file: include/test_mode_pkg.sv
// package for the test mode and bootstrap control block
// assumes a single 125 MHz core clock and no software-visible registers
package test_mode_pkg;
    localparam int MODE_W = 3;
    localparam int GPIO_W = 16;
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_ISOLATE = 3'h3;
    localparam logic [15:0] BOOT_RESET = 16'h0000;
    localparam logic [15:0] GPIO_DIR_RESET = 16'h0000;
    localparam logic [15:0] GPIO_OUT_RESET = 16'h0000;
    localparam logic [15:0] OE_ALL_OFF = 16'hffff;

    typedef enum logic [2:0] {
        normal_operation_select = 3'b001,
        output_isolation_select = 3'b010,
        reserved_select = 3'b100
    } test_mode_t;
endpackage

// file: logic/test_mode_bootstrap_control.sv
// test mode decode, output isolation and gpio bootstrap capture
// assumes the external reset pin is level-sampled on i_clk; i_rst_b is the internal reset
//
// Contract
// - mode code 000 selects normal operation and 011 selects output isolation.
// - in isolation mode every output and bidirectional output driver is released.
// - in normal mode the boundary scan port stays usable through its dedicated pins.
// - the mode inputs default to normal when left floating, by internal pull-down.
// - in normal mode all sixteen gpio pins are captured on the rising edge of external reset as bootstrap options.
// - gpio direction is set by the administration control module only after internal reset is released.
`timescale 1ns/1ps
module test_mode_bootstrap_control (
    input wire logic i_clk, // core clock, 125 MHz
    input wire logic i_rst_b, // internal reset, async, active low
    input wire logic [2:0] i_test_mode, // test mode pins, pulled low on the pad
    input wire logic i_ext_rst_b, // external reset pin level, active low
    input wire logic [15:0] i_gpio_in, // gpio pad input levels
    input wire logic [15:0] i_adm_gpio_dir, // admin module: 1 = gpio drives
    input wire logic [15:0] i_adm_gpio_out, // admin module gpio output data
    input wire logic i_adm_gpio_we, // admin module direction/data write strobe
    input wire logic i_core_out_oe_b, // core's combined output enable, low = drive
    output logic [15:0] o_gpio_out, // gpio pad output data
    output logic [15:0] o_gpio_oe_b, // gpio pad enables, low = drive
    output logic o_core_out_oe_b, // enable for all other pins, low = drive
    output logic [15:0] o_boot_opt, // captured bootstrap options
    output logic o_boot_valid, // bootstrap options captured
    output logic o_jtag_en, // boundary scan port enabled
    output logic o_isolate, // output isolation active
    output logic o_mode_reserved // reserved mode code seen
);
    test_mode_pkg::test_mode_t mode_d, mode_q;
    logic ext_rst_d, ext_rst_q;
    logic [15:0] boot_d, boot_q;
    logic boot_vld_d, boot_vld_q;
    logic [15:0] dir_d, dir_q, dout_d, dout_q;
    logic [15:0] gpio_oe_b_d, gpio_oe_b_q;
    logic core_oe_b_d, core_oe_b_q;
    logic jtag_en_d, jtag_en_q;
    logic isolate_d, isolate_q;
    logic reserved_d, reserved_q;
    logic capture_edge;

    function automatic test_mode_pkg::test_mode_t decode_mode(input logic [2:0] code);
        case (code)
            test_mode_pkg::MODE_NORMAL: begin
                decode_mode = test_mode_pkg::normal_operation_select;
            end
            test_mode_pkg::MODE_ISOLATE: begin
                decode_mode = test_mode_pkg::output_isolation_select;
            end
            default: begin
                decode_mode = test_mode_pkg::reserved_select;
            end
        endcase
    endfunction

    // pad enables for the gpio ring; isolation overrides the direction bits
    function automatic logic [15:0] gpio_enable_b(input test_mode_pkg::test_mode_t mode, input logic [15:0] dir);
        case (mode)
            test_mode_pkg::output_isolation_select: begin
                gpio_enable_b = test_mode_pkg::OE_ALL_OFF;
            end
            test_mode_pkg::normal_operation_select: begin
                gpio_enable_b = ~dir;
            end
            default: begin
                gpio_enable_b = ~dir;
            end
        endcase
    endfunction

    function automatic logic core_enable_b(input test_mode_pkg::test_mode_t mode, input logic core_oe_b);
        case (mode)
            test_mode_pkg::output_isolation_select: begin
                core_enable_b = 1'b1;
            end
            test_mode_pkg::normal_operation_select: begin
                core_enable_b = core_oe_b;
            end
            default: begin
                core_enable_b = core_oe_b;
            end
        endcase
    endfunction

    // low-to-high step of the sampled external reset while the mode flop says normal
    function automatic logic boot_edge(input logic prev_b, input logic now_b, input test_mode_pkg::test_mode_t mode);
        boot_edge = !prev_b && now_b && (mode == test_mode_pkg::normal_operation_select);
    endfunction

    // mode decode; status flags are registered beside the mode flop so they share its latency
    always_comb begin
        mode_d = decode_mode(i_test_mode);
        jtag_en_d = 1'b0;
        isolate_d = 1'b0;
        reserved_d = 1'b0;
        case (mode_d)
            test_mode_pkg::normal_operation_select: begin
                jtag_en_d = 1'b1;
            end
            test_mode_pkg::output_isolation_select: begin
                isolate_d = 1'b1;
            end
            default: begin
                reserved_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_q <= test_mode_pkg::normal_operation_select;
            jtag_en_q <= 1'b1;
            isolate_q <= 1'b0;
            reserved_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            jtag_en_q <= jtag_en_d;
            isolate_q <= isolate_d;
            reserved_q <= reserved_d;
        end
    end

    // bootstrap capture
    always_comb begin
        ext_rst_d = i_ext_rst_b;
        boot_d = boot_q;
        boot_vld_d = boot_vld_q;
        capture_edge = boot_edge(ext_rst_q, i_ext_rst_b, mode_q);
        // pads are taken on the step that the reset pin makes from low to high
        if (capture_edge) begin
            boot_d = i_gpio_in;
            boot_vld_d = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ext_rst_q <= 1'b0;
            boot_q <= test_mode_pkg::BOOT_RESET;
            boot_vld_q <= 1'b0;
        end else begin
            ext_rst_q <= ext_rst_d;
            boot_q <= boot_d;
            boot_vld_q <= boot_vld_d;
        end
    end

    // gpio direction and data owned by the administration control module
    always_comb begin
        dir_d = dir_q;
        dout_d = dout_q;
        // flops are held in reset until internal release, so writes only land afterwards
        if (i_adm_gpio_we) begin
            dir_d = i_adm_gpio_dir;
            dout_d = i_adm_gpio_out;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dir_q <= test_mode_pkg::GPIO_DIR_RESET;
            dout_q <= test_mode_pkg::GPIO_OUT_RESET;
        end else begin
            dir_q <= dir_d;
            dout_q <= dout_d;
        end
    end

    // pad enables follow the direction written in the same cycle
    always_comb begin
        gpio_oe_b_d = gpio_enable_b(mode_q, dir_d);
        core_oe_b_d = core_enable_b(mode_q, i_core_out_oe_b);
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gpio_oe_b_q <= test_mode_pkg::OE_ALL_OFF;
            core_oe_b_q <= 1'b1;
        end else begin
            gpio_oe_b_q <= gpio_oe_b_d;
            core_oe_b_q <= core_oe_b_d;
        end
    end

    assign o_gpio_out = dout_q;
    assign o_gpio_oe_b = gpio_oe_b_q;
    assign o_core_out_oe_b = core_oe_b_q;
    assign o_boot_opt = boot_q;
    assign o_boot_valid = boot_vld_q;
    assign o_jtag_en = jtag_en_q;
    assign o_isolate = isolate_q;
    assign o_mode_reserved = reserved_q;
endmodule

// file: dv/tm_props.sv
// checker for the test mode block
// bound to its top module, one clock
`timescale 1ns/1ps
module tm_props(input logic i_clk, i_rst_b, i_adm_gpio_we, i_core_out_oe_b, o_isolate, o_jtag_en, o_mode_reserved,
    o_core_out_oe_b, o_boot_valid, input logic [2:0] i_test_mode, input logic [15:0] i_adm_gpio_out, o_gpio_out,
    input logic [15:0] o_gpio_oe_b);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    a_iso_dec: assert property (i_test_mode == 3'h3 |=> o_isolate && !o_jtag_en) else $error("iso");
    a_scan_on: assert property (i_test_mode == 3'h0 |=> o_jtag_en && !o_mode_reserved) else $error("jtag");
    a_rsv_flag: assert property (o_mode_reserved != (o_jtag_en | o_isolate)) else $error("rsv");
    a_iso_oe: assert property (o_isolate |=> o_core_out_oe_b && &o_gpio_oe_b) else $error("oe");
    a_core_oe: assert property (!o_isolate |=> o_core_out_oe_b == $past(i_core_out_oe_b)) else $error("co");
    a_gpio_out: assert property (i_adm_gpio_we |=> o_gpio_out == $past(i_adm_gpio_out)) else $error("out");
    a_boot_gate: assert property ($rose(o_boot_valid) |-> $past(o_jtag_en)) else $error("gate");
    a_boot_hold: assert property (o_boot_valid |=> o_boot_valid) else $error("bv");
endmodule
bind test_mode_bootstrap_control tm_props u_props(.*);

// file: dv/board_model.sv
// board tester model for mode pins, reset and pads
// needs the bench clock
`timescale 1ns/1ps
module board_model(input logic i_clk, output logic [2:0] o_mode = 0, output logic o_ext_b = 0,
    output logic [15:0] o_pad = 0);
    task automatic apply(input logic [2:0] m, input logic [15:0] p);
        @(posedge i_clk) {o_mode, o_ext_b, o_pad} <= {m, 1'b0, p};
        @(posedge i_clk) o_ext_b <= 1'b1;
        // pads no longer held once the reset has risen
        @(posedge i_clk) o_pad <= ~p;
    endtask
endmodule

// file: dv/tb_test_mode_bootstrap_control.sv
// bench for the test mode block
// 125 MHz clock, async reset
`timescale 1ns/1ps
module tb_test_mode_bootstrap_control;
    logic i_clk = 0, i_rst_b = 0, i_adm_gpio_we = 0, i_core_out_oe_b = 0, i_ext_rst_b, o_isolate, o_jtag_en;
    logic o_mode_reserved, o_core_out_oe_b, o_boot_valid;
    logic [2:0] i_test_mode;
    logic [15:0] i_adm_gpio_dir = 0, i_adm_gpio_out = 0, i_gpio_in, o_gpio_out, o_gpio_oe_b, o_boot_opt;
    int n_mismatch = 0, check_count = 0, v;
    int boot_hist[$];
    board_model bm(.i_clk(i_clk), .o_mode(i_test_mode), .o_ext_b(i_ext_rst_b), .o_pad(i_gpio_in));
    test_mode_bootstrap_control uut(.*);
    initial forever #4 i_clk = ~i_clk;
    task automatic cmp(input string s, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic chk_boot(input logic [15:0] e, input logic ev);
        cmp("boot_opt", e, o_boot_opt);
        cmp("boot_valid", {15'h0, ev}, {15'h0, o_boot_valid});
    endtask
    task automatic chk_pad(input logic [15:0] eoe, input logic [15:0] eout, input logic ecore);
        cmp("gpio_oe_b", eoe, o_gpio_oe_b);
        cmp("gpio_out", eout, o_gpio_out);
        cmp("core_oe_b", {15'h0, ecore}, {15'h0, o_core_out_oe_b});
    endtask
    task automatic chk_mode(input int m);
        cmp("jtag_en", {15'h0, m == test_mode_pkg::MODE_NORMAL}, {15'h0, o_jtag_en});
        cmp("isolate", {15'h0, m == test_mode_pkg::MODE_ISOLATE}, {15'h0, o_isolate});
        cmp("reserved", {15'h0, m != test_mode_pkg::MODE_NORMAL && m != test_mode_pkg::MODE_ISOLATE},
            {15'h0, o_mode_reserved});
    endtask
    task automatic end_of_test(input int late);
        n_mismatch += late;
        if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // about 45 cycles of tests; the limit leaves a wide margin
    initial begin
        repeat (1000) @(posedge i_clk);
        end_of_test(1);
    end
    initial begin
        v = $urandom(88668);
        @(posedge i_clk);
        @(posedge i_clk) i_rst_b <= 1'b1;
        @(negedge i_clk);
        chk_mode(0);
        chk_boot(16'h0, 1'b0);
        chk_pad(16'hffff, 16'h0, 1'b1);
        for (int m = 0; m < 8; m++) begin
            v = $urandom;
            bm.apply(m[2:0], v[15:0]);
            if (m == 0) boot_hist.push_back(v[15:0]);
            @(posedge i_clk) {i_adm_gpio_we, i_adm_gpio_dir, i_adm_gpio_out, i_core_out_oe_b} <= {1'b1, v, v[16]};
            @(posedge i_clk) i_adm_gpio_we <= 0;
            @(negedge i_clk);
            chk_boot(boot_hist[$], 1'b1);
            chk_mode(m);
            chk_pad(m == 3 ? 16'hffff : ~v[31:16], v[15:0], m == 3 ? 1'b1 : v[16]);
        end
        @(posedge i_clk) i_rst_b <= 1'b0;
        @(negedge i_clk);
        chk_boot(16'h0, 1'b0);
        chk_pad(16'hffff, 16'h0, 1'b1);
        chk_mode(0);
        // reset pin already high at release counts as a rise while the mode flop is still normal
        @(posedge i_clk) i_rst_b <= 1'b1;
        @(posedge i_clk);
        @(negedge i_clk);
        chk_boot(i_gpio_in, 1'b1);
        chk_mode(7);
        chk_pad(16'hffff, 16'h0, v[16]);
        end_of_test(0);
    end
endmodule
